// *** dosm_state_machine.sv ***
`include "dosm_map.svh"
// How it works
// - start leaves for not-ready once electronics initialisation completes
// - switch-on-disabled to ready on no undervoltage, both safety inputs high, or shutdown
// - ready to switched-on on internal enable request or switch-on command
// - switched-on to enabled automatically, or on enable-op after fieldbus switch-on
// - entering enabled from switched-on turns power stage on, validates parameters, releases brake
// - disable-op in enabled returns to switched-on with halt, brake, power off
// - shutdown takes switched-on or enabled to ready; power off at once
// - ready drops to disabled on undervoltage, a low safety input, or disable-voltage
// - disable request or disable-voltage sends states 5, 6, 7 to disabled
// - leaving quick-stop to disabled switches power stage off immediately
// - class 1 error or quick-stop command in enabled enters quick-stop with quick stop
// - class 2, 3 or 4 error in any state but fault-response and fault enters fault-response and starts response
// - fault-response goes to fault when class 2 response ends, or directly for 3, 4
// - fault-reset in fault clears the error and returns to disabled
// - quick-stop returns to enabled on fault-reset, or enable-op if fieldbus triggered
// - any one listed condition suffices for a transition
// - fieldbus commands act only in fieldbus control mode
`timescale 1ns/1ps
`default_nettype none

module dosm_state_machine (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic init_done_i,
    input wire logic undervoltage_i,
    input wire logic safe_torque_off_input_a_i,
    input wire logic safe_torque_off_input_b_i,
    input wire logic fieldbus_mode_i,
    input wire logic cmd_valid_i,
    input wire dosm_pkg::dosm_cmd_type cmd_i,
    input wire logic enable_req_i,
    input wire logic disable_req_i,
    input wire logic [2:0] err_class_i,
    input wire logic err_resp_done_i,
    input wire logic fault_reset_i,
    output logic [3:0] state_code_o,
    output logic power_stage_en_o,
    output logic brake_release_o,
    output logic param_check_o,
    output logic halt_o,
    output logic quick_stop_o,
    output logic error_response_o,
    output logic error_clear_o
);
    dosm_pkg::dosm_state_type state_reg;
    dosm_pkg::dosm_state_type state_next;
    dosm_pkg::dosm_cmd_type cmd;
    logic [1:0] sto_sync;
    logic uv_sync;
    logic sw_on_by_bus_reg;
    logic sw_on_by_bus_next;
    logic qs_by_bus_reg;
    logic qs_by_bus_next;
    logic [2:0] err_class_reg;
    logic [2:0] err_class_next;
    logic [3:0] state_code_reg;
    logic power_stage_en_reg;
    logic brake_release_reg;
    logic param_check_reg;
    logic halt_reg;
    logic quick_stop_reg;
    logic error_response_reg;
    logic error_clear_reg;

    // pins from the safety chain and supply monitor cross into this clock
    dosm_sync #(.WIDTH(2)) u_sto_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({safe_torque_off_input_b_i, safe_torque_off_input_a_i}),
        .sync_o(sto_sync)
    );

    dosm_sync #(.WIDTH(1)) u_uv_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(undervoltage_i),
        .sync_o(uv_sync)
    );

    dosm_cmd_gate u_cmd_gate (
        .fieldbus_mode_i(fieldbus_mode_i),
        .cmd_i(cmd_i),
        .cmd_valid_i(cmd_valid_i),
        .cmd_o(cmd)
    );

    function automatic logic [3:0] dosm_code(input dosm_pkg::dosm_state_type s);
        case (s)
            dosm_pkg::DOSM_S_START: dosm_code = `DOSM_ST_START;
            dosm_pkg::DOSM_S_NOT_READY: dosm_code = `DOSM_ST_NOT_READY;
            dosm_pkg::DOSM_S_SW_ON_DIS: dosm_code = `DOSM_ST_SW_ON_DIS;
            dosm_pkg::DOSM_S_READY: dosm_code = `DOSM_ST_READY;
            dosm_pkg::DOSM_S_SWITCHED_ON: dosm_code = `DOSM_ST_SWITCHED_ON;
            dosm_pkg::DOSM_S_OP_ENABLED: dosm_code = `DOSM_ST_OP_ENABLED;
            dosm_pkg::DOSM_S_QSTOP: dosm_code = `DOSM_ST_QSTOP;
            dosm_pkg::DOSM_S_FAULT_RESP: dosm_code = `DOSM_ST_FAULT_RESP;
            dosm_pkg::DOSM_S_FAULT: dosm_code = `DOSM_ST_FAULT;
            default: dosm_code = `DOSM_ST_START;
        endcase
    endfunction

    wire undervolt = uv_sync;
    wire sto_both_high = sto_sync[0] && sto_sync[1];
    wire sto_any_low = !sto_sync[0] || !sto_sync[1];
    wire err_c1 = (err_class_i == `DOSM_ERR_C1);
    wire err_severe = (err_class_i == `DOSM_ERR_C2) || (err_class_i == `DOSM_ERR_C3)
        || (err_class_i == `DOSM_ERR_C4);
    wire cmd_shutdown = (cmd == dosm_pkg::DOSM_CMD_SHUTDOWN);
    wire cmd_switch_on = (cmd == dosm_pkg::DOSM_CMD_SWITCH_ON);
    wire cmd_enable_op = (cmd == dosm_pkg::DOSM_CMD_ENABLE_OP);
    wire cmd_disable_op = (cmd == dosm_pkg::DOSM_CMD_DISABLE_OP);
    wire cmd_disable_volt = (cmd == dosm_pkg::DOSM_CMD_DISABLE_VOLT);
    wire cmd_quick_stop = (cmd == dosm_pkg::DOSM_CMD_QUICK_STOP);
    wire go_disabled = disable_req_i || cmd_disable_volt;
    wire class2_pending = (err_class_reg == `DOSM_ERR_C2);
    // an already-active response is not restarted by a fresh severe error
    wire in_fault_path = (state_reg == dosm_pkg::DOSM_S_FAULT_RESP) || (state_reg == dosm_pkg::DOSM_S_FAULT);

    always_comb begin
        state_next = state_reg;
        sw_on_by_bus_next = sw_on_by_bus_reg;
        qs_by_bus_next = qs_by_bus_reg;
        err_class_next = err_class_reg;
        if (err_severe && !in_fault_path) begin
            state_next = dosm_pkg::DOSM_S_FAULT_RESP;
            err_class_next = err_class_i;
        end else begin
            case (state_reg)
                dosm_pkg::DOSM_S_START: begin
                    if (init_done_i) state_next = dosm_pkg::DOSM_S_NOT_READY;
                end
                dosm_pkg::DOSM_S_NOT_READY: begin
                    state_next = dosm_pkg::DOSM_S_SW_ON_DIS;
                end
                dosm_pkg::DOSM_S_SW_ON_DIS: begin
                    if (!undervolt || sto_both_high || cmd_shutdown) begin
                        state_next = dosm_pkg::DOSM_S_READY;
                    end
                end
                dosm_pkg::DOSM_S_READY: begin
                    if (undervolt || sto_any_low || cmd_disable_volt) begin
                        state_next = dosm_pkg::DOSM_S_SW_ON_DIS;
                    end else if (enable_req_i || cmd_switch_on) begin
                        state_next = dosm_pkg::DOSM_S_SWITCHED_ON;
                        sw_on_by_bus_next = cmd_switch_on && !enable_req_i;
                    end
                end
                dosm_pkg::DOSM_S_SWITCHED_ON: begin
                    if (go_disabled) state_next = dosm_pkg::DOSM_S_SW_ON_DIS;
                    else if (cmd_shutdown) state_next = dosm_pkg::DOSM_S_READY;
                    else if (!sw_on_by_bus_reg || cmd_enable_op) begin
                        state_next = dosm_pkg::DOSM_S_OP_ENABLED;
                    end
                end
                dosm_pkg::DOSM_S_OP_ENABLED: begin
                    if (err_c1 || cmd_quick_stop) begin
                        state_next = dosm_pkg::DOSM_S_QSTOP;
                        qs_by_bus_next = cmd_quick_stop && !err_c1;
                    end else if (go_disabled) state_next = dosm_pkg::DOSM_S_SW_ON_DIS;
                    else if (cmd_shutdown) state_next = dosm_pkg::DOSM_S_READY;
                    else if (cmd_disable_op) begin
                        state_next = dosm_pkg::DOSM_S_SWITCHED_ON;
                        sw_on_by_bus_next = 1'b1;
                    end
                end
                dosm_pkg::DOSM_S_QSTOP: begin
                    if (go_disabled) state_next = dosm_pkg::DOSM_S_SW_ON_DIS;
                    else if (fault_reset_i || (cmd_enable_op && qs_by_bus_reg)) begin
                        state_next = dosm_pkg::DOSM_S_OP_ENABLED;
                    end
                end
                dosm_pkg::DOSM_S_FAULT_RESP: begin
                    if (!class2_pending || err_resp_done_i) state_next = dosm_pkg::DOSM_S_FAULT;
                end
                dosm_pkg::DOSM_S_FAULT: begin
                    if (fault_reset_i) begin
                        state_next = dosm_pkg::DOSM_S_SW_ON_DIS;
                        err_class_next = `DOSM_ERR_NONE;
                    end
                end
                default: state_next = dosm_pkg::DOSM_S_START;
            endcase
        end
    end

    wire enter_enabled = (state_next == dosm_pkg::DOSM_S_OP_ENABLED) && (state_reg == dosm_pkg::DOSM_S_SWITCHED_ON);
    wire next_powered = (state_next == dosm_pkg::DOSM_S_OP_ENABLED) || (state_next == dosm_pkg::DOSM_S_QSTOP)
        || ((state_next == dosm_pkg::DOSM_S_FAULT_RESP) && (err_class_next == `DOSM_ERR_C2)
        && power_stage_en_reg);
    wire next_halt = (state_reg == dosm_pkg::DOSM_S_OP_ENABLED) && (state_next == dosm_pkg::DOSM_S_SWITCHED_ON);
    wire next_qstop = ((state_reg == dosm_pkg::DOSM_S_OP_ENABLED) && (state_next == dosm_pkg::DOSM_S_QSTOP))
        || ((state_next == dosm_pkg::DOSM_S_FAULT_RESP) && (state_reg != dosm_pkg::DOSM_S_FAULT_RESP)
        && (err_class_next == `DOSM_ERR_C2));
    wire next_resp = (state_next == dosm_pkg::DOSM_S_FAULT_RESP) && (state_reg != dosm_pkg::DOSM_S_FAULT_RESP);
    wire next_clear = (state_reg == dosm_pkg::DOSM_S_FAULT) && (state_next == dosm_pkg::DOSM_S_SW_ON_DIS);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= dosm_pkg::DOSM_S_START;
            sw_on_by_bus_reg <= 1'b0;
            qs_by_bus_reg <= 1'b0;
            err_class_reg <= `DOSM_ERR_NONE;
            state_code_reg <= `DOSM_ST_START;
            power_stage_en_reg <= 1'b0;
            brake_release_reg <= 1'b0;
            param_check_reg <= 1'b0;
            halt_reg <= 1'b0;
            quick_stop_reg <= 1'b0;
            error_response_reg <= 1'b0;
            error_clear_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sw_on_by_bus_reg <= sw_on_by_bus_next;
            qs_by_bus_reg <= qs_by_bus_next;
            err_class_reg <= err_class_next;
            state_code_reg <= dosm_code(state_next);
            power_stage_en_reg <= next_powered;
            brake_release_reg <= next_powered;
            param_check_reg <= enter_enabled;
            halt_reg <= next_halt;
            quick_stop_reg <= next_qstop;
            error_response_reg <= next_resp;
            error_clear_reg <= next_clear;
        end
    end

    assign state_code_o = state_code_reg;
    assign power_stage_en_o = power_stage_en_reg;
    assign brake_release_o = brake_release_reg;
    assign param_check_o = param_check_reg;
    assign halt_o = halt_reg;
    assign quick_stop_o = quick_stop_reg;
    assign error_response_o = error_response_reg;
    assign error_clear_o = error_clear_reg;

    state_reset_a: assert property (@(posedge ref_clk_i) !rst_n_i |=> state_code_o == `DOSM_ST_START)
        else $error("state not start after reset");
    code_range_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_code_o >= `DOSM_ST_START && state_code_o <= `DOSM_ST_FAULT)
        else $error("state code out of range");
    severe_error_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (err_severe && !in_fault_path) |=> state_code_o == `DOSM_ST_FAULT_RESP)
        else $error("severe error did not start fault response");
    power_follows_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_code_o == `DOSM_ST_SW_ON_DIS || state_code_o == `DOSM_ST_READY
        || state_code_o == `DOSM_ST_SWITCHED_ON) |-> !power_stage_en_o)
        else $error("power stage on outside powered states");
    enter_enabled_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_code_o == `DOSM_ST_SWITCHED_ON ##1 state_code_o == `DOSM_ST_OP_ENABLED)
        |-> power_stage_en_o && brake_release_o && param_check_o)
        else $error("entering enabled without power, brake or check");
    auto_enable_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_SWITCHED_ON && !sw_on_by_bus_reg && !err_severe && !go_disabled
        && !cmd_shutdown) |=> state_code_o == `DOSM_ST_OP_ENABLED)
        else $error("automatic enable missed");
    disable_op_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_code_o == `DOSM_ST_OP_ENABLED ##1 state_code_o == `DOSM_ST_SWITCHED_ON)
        |-> halt_o && !power_stage_en_o && !brake_release_o)
        else $error("disable operation response wrong");
    fieldbus_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!fieldbus_mode_i && state_reg == dosm_pkg::DOSM_S_SWITCHED_ON && sw_on_by_bus_reg && !err_severe
        && !disable_req_i) |=> $stable(state_code_o))
        else $error("fieldbus command acted outside fieldbus mode");
    quick_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_OP_ENABLED && err_c1) |=> quick_stop_o
        && state_code_o == `DOSM_ST_QSTOP)
        else $error("class 1 error did not quick stop");
    fault_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_FAULT && fault_reset_i && !err_severe) |=> error_clear_o
        && state_code_o == `DOSM_ST_SW_ON_DIS)
        else $error("fault reset not honoured");
    // transition checks on the start, pin, shutdown, halt, quick-stop and fault paths
    init_leave_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_START && init_done_i && !err_severe)
        |=> state_code_o == `DOSM_ST_NOT_READY) else $error("start state not left after initialisation");
    ready_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_READY && (undervolt || sto_any_low) && !err_severe)
        |=> state_code_o == `DOSM_ST_SW_ON_DIS) else $error("ready kept despite supply or safety loss");
    ready_advance_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_SW_ON_DIS && !undervolt && !err_severe)
        |=> state_code_o == `DOSM_ST_READY) else $error("ready not reached with supply good");
    shutdown_power_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_code_o == `DOSM_ST_OP_ENABLED ##1 state_code_o == `DOSM_ST_READY)
        |-> !power_stage_en_o && !brake_release_o) else $error("power stage on after shutdown");
    halt_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        halt_o |=> !halt_o)
        else $error("halt longer than one cycle");
    qstop_return_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_QSTOP && fault_reset_i && !go_disabled && !err_severe)
        |=> state_code_o == `DOSM_ST_OP_ENABLED) else $error("fault reset did not leave quick stop");
    fault_direct_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg == dosm_pkg::DOSM_S_FAULT_RESP && !class2_pending) |=> state_code_o == `DOSM_ST_FAULT)
        else $error("class 3 or 4 response did not reach fault");
    fault_power_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_code_o == `DOSM_ST_FAULT |-> !power_stage_en_o && !brake_release_o)
        else $error("power stage on in fault state");
    clear_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        error_clear_o |-> state_code_o == `DOSM_ST_SW_ON_DIS)
        else $error("error clear outside fault reset");
endmodule

`default_nettype wire

// *** dosm_map.svh ***
`ifndef DOSM_MAP_SVH
`define DOSM_MAP_SVH

// numeric operating state codes
`define DOSM_ST_START 4'h1
`define DOSM_ST_NOT_READY 4'h2
`define DOSM_ST_SW_ON_DIS 4'h3
`define DOSM_ST_READY 4'h4
`define DOSM_ST_SWITCHED_ON 4'h5
`define DOSM_ST_OP_ENABLED 4'h6
`define DOSM_ST_QSTOP 4'h7
`define DOSM_ST_FAULT_RESP 4'h8
`define DOSM_ST_FAULT 4'h9

// error class codes on err_class_i
`define DOSM_ERR_NONE 3'h0
`define DOSM_ERR_C1 3'h1
`define DOSM_ERR_C2 3'h2
`define DOSM_ERR_C3 3'h3
`define DOSM_ERR_C4 3'h4

`endif

// *** dosm_pkg.sv ***
package dosm_pkg;

    typedef enum logic [2:0] {
        DOSM_CMD_NONE = 3'h0,
        DOSM_CMD_SHUTDOWN = 3'h1,
        DOSM_CMD_SWITCH_ON = 3'h2,
        DOSM_CMD_ENABLE_OP = 3'h3,
        DOSM_CMD_DISABLE_OP = 3'h4,
        DOSM_CMD_DISABLE_VOLT = 3'h5,
        DOSM_CMD_QUICK_STOP = 3'h6
    } dosm_cmd_type;

    // gray codes along start, not ready, disabled, ready, switched on, enabled
    typedef enum logic [3:0] {
        DOSM_S_START = 4'h0,
        DOSM_S_NOT_READY = 4'h1,
        DOSM_S_SW_ON_DIS = 4'h3,
        DOSM_S_READY = 4'h2,
        DOSM_S_SWITCHED_ON = 4'h6,
        DOSM_S_OP_ENABLED = 4'h7,
        DOSM_S_QSTOP = 4'h5,
        DOSM_S_FAULT_RESP = 4'h4,
        DOSM_S_FAULT = 4'hc
    } dosm_state_type;

endpackage

// *** dosm_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module dosm_sync #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

`default_nettype wire

// *** dosm_cmd_gate.sv ***
`timescale 1ns/1ps
`default_nettype none

// passes a fieldbus command only in fieldbus control mode
module dosm_cmd_gate (
    input wire logic fieldbus_mode_i,
    input wire dosm_pkg::dosm_cmd_type cmd_i,
    input wire logic cmd_valid_i,
    output dosm_pkg::dosm_cmd_type cmd_o
);
    assign cmd_o = (fieldbus_mode_i && cmd_valid_i) ? cmd_i : dosm_pkg::DOSM_CMD_NONE;
endmodule

`default_nettype wire

// *** dosm_fieldbus_master.sv ***
`timescale 1ns/1ps
`default_nettype none

// fieldbus controller stand-in; commands are one-cycle strobes
module dosm_fieldbus_master (
    input wire logic ref_clk_i,
    output dosm_pkg::dosm_cmd_type cmd_o,
    output logic cmd_valid_o,
    output logic fieldbus_mode_o
);
    initial begin
        cmd_o = dosm_pkg::DOSM_CMD_NONE;
        cmd_valid_o = 1'b0;
        fieldbus_mode_o = 1'b1;
    end

    // called at a falling edge; idle lets a slow controller be modelled
    task automatic send(input dosm_pkg::dosm_cmd_type cmd, input int idle);
        repeat (idle) @(negedge ref_clk_i);
        cmd_o = cmd;
        cmd_valid_o = 1'b1;
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b0;
        // idle code, so a stale command cannot pass for a new one
        cmd_o = dosm_pkg::DOSM_CMD_NONE;
    endtask

    task automatic set_mode(input logic fb);
        fieldbus_mode_o = fb;
    endtask
endmodule

`default_nettype wire

// *** testbench.sv ***
`include "dosm_map.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic ref_clk, rst_n, init_done, undervoltage, safety_a, safety_b, enable_req, disable_req;
    logic err_resp_done, fault_reset, cmd_valid, fb_mode;
    logic [2:0] err_class;
    dosm_pkg::dosm_cmd_type cmd;
    logic [3:0] state_code;
    logic power_en, brake_rel, param_chk, halt, qstop, err_resp, err_clr;
    int error_cnt = 0;
    int check_count = 0;

    dosm_fieldbus_master i_dosm_fieldbus_master (.ref_clk_i(ref_clk), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
        .fieldbus_mode_o(fb_mode));

    dosm_state_machine i_dosm_state_machine (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .init_done_i(init_done),
        .undervoltage_i(undervoltage), .safe_torque_off_input_a_i(safety_a),
        .safe_torque_off_input_b_i(safety_b),
        .fieldbus_mode_i(fb_mode), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .enable_req_i(enable_req),
        .disable_req_i(disable_req), .err_class_i(err_class), .err_resp_done_i(err_resp_done),
        .fault_reset_i(fault_reset), .state_code_o(state_code), .power_stage_en_o(power_en),
        .brake_release_o(brake_rel), .param_check_o(param_chk), .halt_o(halt), .quick_stop_o(qstop),
        .error_response_o(err_resp), .error_clear_o(err_clr));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk_state(input logic [3:0] exp);
        check_count++;
        if (state_code !== exp) begin
            $display("[ERR] state_code expected %0h seen %0h", exp, state_code);
            error_cnt++;
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %b seen %b", name, exp, got);
            error_cnt++;
        end
    endtask

    // bounded wait, for paths through the pin synchronisers
    task automatic wait_state(input logic [3:0] exp, input int max);
        for (int i = 0; i < max && state_code !== exp; i++) begin
            tick(1);
        end
        chk_state(exp);
    endtask

    task automatic send(input dosm_pkg::dosm_cmd_type c);
        i_dosm_fieldbus_master.send(c, 0);
    endtask

    task automatic to_enabled();
        enable_req = 1'b1;
        tick(1);
        enable_req = 1'b0;
        chk_state(`DOSM_ST_SWITCHED_ON);
        tick(1);
        chk_state(`DOSM_ST_OP_ENABLED);
        chk_bit("power_stage_en", 1'b1, power_en);
        chk_bit("brake_release", 1'b1, brake_rel);
        chk_bit("param_check", 1'b1, param_chk);
    endtask

    task automatic t_bring_up();
        init_done = 1'b1;
        tick(1);
        chk_state(`DOSM_ST_NOT_READY);
        tick(1);
        chk_state(`DOSM_ST_SW_ON_DIS);
        tick(1);
        chk_state(`DOSM_ST_READY);
        to_enabled();
    endtask

    task automatic t_disable_op();
        send(dosm_pkg::DOSM_CMD_DISABLE_OP);
        chk_state(`DOSM_ST_SWITCHED_ON);
        chk_bit("halt", 1'b1, halt);
        chk_bit("power_stage_en", 1'b0, power_en);
        chk_bit("brake_release", 1'b0, brake_rel);
        tick(2);
        chk_state(`DOSM_ST_SWITCHED_ON);
        send(dosm_pkg::DOSM_CMD_ENABLE_OP);
        chk_state(`DOSM_ST_OP_ENABLED);
    endtask

    task automatic t_quick_stop();
        send(dosm_pkg::DOSM_CMD_QUICK_STOP);
        chk_state(`DOSM_ST_QSTOP);
        chk_bit("quick_stop", 1'b1, qstop);
        send(dosm_pkg::DOSM_CMD_ENABLE_OP);
        chk_state(`DOSM_ST_OP_ENABLED);
        err_class = `DOSM_ERR_C1;
        tick(1);
        err_class = `DOSM_ERR_NONE;
        chk_state(`DOSM_ST_QSTOP);
        chk_bit("quick_stop", 1'b1, qstop);
        send(dosm_pkg::DOSM_CMD_ENABLE_OP);
        chk_state(`DOSM_ST_QSTOP);
        fault_reset = 1'b1;
        tick(1);
        fault_reset = 1'b0;
        chk_state(`DOSM_ST_OP_ENABLED);
        send(dosm_pkg::DOSM_CMD_QUICK_STOP);
        disable_req = 1'b1;
        tick(1);
        disable_req = 1'b0;
        chk_state(`DOSM_ST_SW_ON_DIS);
        chk_bit("power_stage_en", 1'b0, power_en);
        tick(1);
        chk_state(`DOSM_ST_READY);
    endtask

    task automatic t_commands();
        send(dosm_pkg::DOSM_CMD_SWITCH_ON);
        chk_state(`DOSM_ST_SWITCHED_ON);
        tick(3);
        chk_state(`DOSM_ST_SWITCHED_ON);
        i_dosm_fieldbus_master.set_mode(1'b0);
        send(dosm_pkg::DOSM_CMD_ENABLE_OP);
        chk_state(`DOSM_ST_SWITCHED_ON);
        i_dosm_fieldbus_master.set_mode(1'b1);
        send(dosm_pkg::DOSM_CMD_ENABLE_OP);
        chk_state(`DOSM_ST_OP_ENABLED);
        send(dosm_pkg::DOSM_CMD_SHUTDOWN);
        chk_state(`DOSM_ST_READY);
        chk_bit("power_stage_en", 1'b0, power_en);
        send(dosm_pkg::DOSM_CMD_SWITCH_ON);
        chk_state(`DOSM_ST_SWITCHED_ON);
        send(dosm_pkg::DOSM_CMD_SHUTDOWN);
        chk_state(`DOSM_ST_READY);
        i_dosm_fieldbus_master.set_mode(1'b0);
        send(dosm_pkg::DOSM_CMD_SWITCH_ON);
        tick(2);
        chk_state(`DOSM_ST_READY);
        i_dosm_fieldbus_master.set_mode(1'b1);
        send(dosm_pkg::DOSM_CMD_DISABLE_VOLT);
        chk_state(`DOSM_ST_SW_ON_DIS);
        tick(1);
        to_enabled();
        send(dosm_pkg::DOSM_CMD_DISABLE_VOLT);
        chk_state(`DOSM_ST_SW_ON_DIS);
        chk_bit("power_stage_en", 1'b0, power_en);
    endtask

    task automatic t_pins();
        wait_state(`DOSM_ST_READY, 4);
        safety_a = 1'b0;
        undervoltage = 1'b1;
        wait_state(`DOSM_ST_SW_ON_DIS, 6);
        tick(3);
        chk_state(`DOSM_ST_SW_ON_DIS);
        send(dosm_pkg::DOSM_CMD_SHUTDOWN);
        chk_state(`DOSM_ST_READY);
        safety_a = 1'b1;
        undervoltage = 1'b0;
        tick(4);
        wait_state(`DOSM_ST_READY, 8);
        safety_b = 1'b0;
        wait_state(`DOSM_ST_SW_ON_DIS, 6);
        safety_b = 1'b1;
        tick(4);
        wait_state(`DOSM_ST_READY, 8);
    endtask

    // cause removed before the fault reset is issued
    task automatic clear_fault();
        fault_reset = 1'b1;
        tick(1);
        fault_reset = 1'b0;
        chk_state(`DOSM_ST_SW_ON_DIS);
        chk_bit("error_clear", 1'b1, err_clr);
        tick(1);
    endtask

    task automatic t_errors();
        to_enabled();
        err_class = `DOSM_ERR_C3;
        tick(1);
        err_class = `DOSM_ERR_NONE;
        chk_state(`DOSM_ST_FAULT_RESP);
        chk_bit("error_response", 1'b1, err_resp);
        chk_bit("power_stage_en", 1'b0, power_en);
        tick(1);
        chk_state(`DOSM_ST_FAULT);
        tick(2);
        chk_state(`DOSM_ST_FAULT);
        clear_fault();
        err_class = `DOSM_ERR_C2;
        tick(1);
        err_class = `DOSM_ERR_NONE;
        chk_bit("quick_stop", 1'b1, qstop);
        tick(3);
        chk_state(`DOSM_ST_FAULT_RESP);
        err_resp_done = 1'b1;
        tick(1);
        err_resp_done = 1'b0;
        chk_state(`DOSM_ST_FAULT);
        clear_fault();
        to_enabled();
        err_class = `DOSM_ERR_C4;
        send(dosm_pkg::DOSM_CMD_QUICK_STOP);
        err_class = `DOSM_ERR_NONE;
        chk_state(`DOSM_ST_FAULT_RESP);
        tick(1);
        chk_state(`DOSM_ST_FAULT);
        clear_fault();
        to_enabled();
        err_class = `DOSM_ERR_C2;
        tick(1);
        err_class = `DOSM_ERR_NONE;
        chk_state(`DOSM_ST_FAULT_RESP);
        chk_bit("quick_stop", 1'b1, qstop);
        chk_bit("power_stage_en", 1'b1, power_en);
        err_resp_done = 1'b1;
        tick(1);
        err_resp_done = 1'b0;
        chk_state(`DOSM_ST_FAULT);
        chk_bit("power_stage_en", 1'b0, power_en);
        clear_fault();
    endtask

    initial begin
        {rst_n, init_done, undervoltage, enable_req, disable_req, err_resp_done, fault_reset} = 7'h00;
        {safety_a, safety_b} = 2'h3;
        err_class = `DOSM_ERR_NONE;
        repeat (12) @(posedge ref_clk);
        tick(1);
        chk_state(`DOSM_ST_START);
        chk_bit("power_stage_en", 1'b0, power_en);
        rst_n = 1'b1;
        tick(3);
        chk_state(`DOSM_ST_START);
        t_bring_up();
        t_disable_op();
        t_quick_stop();
        t_commands();
        t_pins();
        t_errors();
        tally_and_finish();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
